// [logic/pao_pkg.sv]
// Package: constants, types and register map of the process alarm and output period block
package pao_pkg;
  localparam int DW = 16;
  localparam int NALM = 3;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_SP = 8'h08;
  localparam logic [7:0] OFF_HPER = 8'h0C;
  localparam logic [7:0] OFF_CPER = 8'h10;
  localparam logic [7:0] OFF_SOAK = 8'h14;
  localparam logic [7:0] OFF_MV = 8'h18;
  localparam logic [7:0] OFF_ALM0 = 8'h20;
  localparam int ALM_STRIDE = 16;
  localparam logic [7:0] OFF_ATYPE = 8'h00;
  localparam logic [7:0] OFF_AVAL = 8'h04;
  localparam logic [7:0] OFF_AHI = 8'h08;
  localparam logic [7:0] OFF_ALO = 8'h0C;
  localparam logic [7:0] OFF_HYS0 = 8'h50;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int CTRL_W = 5;
  localparam int BIT_RUN = 5;
  localparam int BIT_START = 6;
  localparam logic [1:0] PAT_OFF = 2'h0;
  localparam logic [1:0] PAT_STOP = 2'h1;
  localparam logic [1:0] PAT_CONT = 2'h2;
  typedef struct packed {
    logic linearHeat;
    logic heatCool;
    logic direct;
    logic [1:0] pattern;
  } pao_ctrl_t;
  // ----------------------------------------
  // Reset values and limits
  // ----------------------------------------
  localparam pao_ctrl_t CTRL_RST = '0;
  localparam logic [7:0] PER_RST = 8'h14;
  localparam logic [7:0] PER_MAX = 8'h63;
  localparam logic [3:0] TYPE_RST = 4'h2;
  localparam logic [3:0] TYPE_MAX = 4'hD;
  localparam logic [3:0] TYPE_LBA = 4'hC;
  localparam logic [3:0] TYPE_RATE = 4'hD;
  localparam logic [DW-1:0] HYS_RST = 16'h0002;
  localparam logic [DW-1:0] HYS_MIN = 16'h0001;
  localparam logic [DW-1:0] HYS_MAX = 16'h270F;
  localparam logic [7:0] MV_MAX = 8'h64;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int HALF_SEC_MS = 500;
  localparam int STEPS_PER_HALF = 100;
  localparam int CENTI_CYC = HALF_SEC_MS * 1000 * CLK_MHZ / STEPS_PER_HALF;
  localparam int STEPS_PER_SEC = 2 * STEPS_PER_HALF;
  typedef enum logic [1:0] {PG_IDLE, PG_SOAK, PG_DONE} pao_prog_t;
endpackage

// [logic/pao_top.sv]
// Process alarm evaluation, time-proportioned outputs and simple program
`timescale 1ns/1ps
module pao_top #(
  parameter int CENTI_CYC = pao_pkg::CENTI_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [15:0] rdata,
  input wire logic signed [15:0] pv,
  output logic heatOut,
  output logic coolOut,
  output logic [2:0] alarmOut,
  output logic runState,
  output logic progActive,
  output logic [7:0] mvHeat,
  output logic [7:0] mvCool
);
  localparam int NA = pao_pkg::NALM;
  localparam int CW = $clog2(CENTI_CYC + 1);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  pao_pkg::pao_ctrl_t ctrl_r;
  logic signed [15:0] sp_r;
  logic [7:0] per_r [2];
  logic [15:0] soak_r;
  logic [3:0] aType_r [NA];
  logic signed [15:0] aVal_r [NA];
  logic signed [15:0] aHi_r [NA];
  logic signed [15:0] aLo_r [NA];
  logic [15:0] aHys_r [NA];
  logic [15:0] rdNxt;
  logic wrCtrl;
  logic runSet;
  logic runClr;
  logic progStart;
  logic progStop;
  logic runPrev_r;
  logic runStart;
  logic [2:0] almRaw;

  assign wrCtrl = ce && we && (addr == pao_pkg::OFF_CTRL);
  assign runSet = wrCtrl && wdata[pao_pkg::BIT_RUN];
  assign runClr = wrCtrl && !wdata[pao_pkg::BIT_RUN];
  assign progStart = wrCtrl && wdata[pao_pkg::BIT_START];

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_r <= pao_pkg::CTRL_RST;
      sp_r <= '0;
      per_r[0] <= pao_pkg::PER_RST;
      per_r[1] <= pao_pkg::PER_RST;
      soak_r <= '0;
    end else if (ce && we) begin
      case (addr)
        pao_pkg::OFF_CTRL: ctrl_r <= pao_pkg::pao_ctrl_t'(wdata[pao_pkg::CTRL_W-1:0]);
        pao_pkg::OFF_SP: sp_r <= wdata;
        pao_pkg::OFF_HPER: begin
          // Zero encodes 0.5 s; out-of-range writes keep the old value
          if (wdata <= 16'(pao_pkg::PER_MAX)) begin
            per_r[0] <= wdata[7:0];
          end
        end
        pao_pkg::OFF_CPER: begin
          if (wdata <= 16'(pao_pkg::PER_MAX)) begin
            per_r[1] <= wdata[7:0];
          end
        end
        pao_pkg::OFF_SOAK: soak_r <= wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Run state and simple program
  // ----------------------------------------
  pao_pkg::pao_prog_t prog_r;
  logic [15:0] soakLeft_r;
  logic [7:0] secCnt_r;
  logic [CW-1:0] centiCnt_r;
  logic centiTick;
  logic secTick;

  assign centiTick = (centiCnt_r == CW'(CENTI_CYC - 1));
  assign secTick = centiTick && (secCnt_r == 8'(pao_pkg::STEPS_PER_SEC - 1));

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      centiCnt_r <= '0;
      secCnt_r <= '0;
    end else if (ce) begin
      centiCnt_r <= centiTick ? '0 : centiCnt_r + 1'b1;
      if (centiTick) begin
        secCnt_r <= secTick ? 8'h00 : secCnt_r + 8'h01;
      end
    end
  end

  assign progStop = (prog_r == pao_pkg::PG_SOAK) && (soakLeft_r == 16'h0000) &&
                    (ctrl_r.pattern == pao_pkg::PAT_STOP);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prog_r <= pao_pkg::PG_IDLE;
      soakLeft_r <= '0;
    end else if (ce) begin
      case (prog_r)
        pao_pkg::PG_IDLE: begin
          // A start with the pattern off is dropped
          if (progStart && ctrl_r.pattern != pao_pkg::PAT_OFF) begin
            prog_r <= pao_pkg::PG_SOAK;
            soakLeft_r <= soak_r;
          end
        end
        pao_pkg::PG_SOAK: begin
          if (ctrl_r.pattern == pao_pkg::PAT_OFF) begin
            prog_r <= pao_pkg::PG_IDLE;
          end else if (soakLeft_r == 16'h0000) begin
            prog_r <= pao_pkg::PG_DONE;
          end else if (secTick && runState) begin
            soakLeft_r <= soakLeft_r - 16'h0001;
          end
        end
        pao_pkg::PG_DONE: begin
          if (progStart && ctrl_r.pattern != pao_pkg::PAT_OFF) begin
            prog_r <= pao_pkg::PG_SOAK;
            soakLeft_r <= soak_r;
          end else if (ctrl_r.pattern == pao_pkg::PAT_OFF) begin
            prog_r <= pao_pkg::PG_IDLE;
          end
        end
        default: prog_r <= pao_pkg::PG_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      runState <= 1'b0;
      runPrev_r <= 1'b0;
    end else if (ce) begin
      runPrev_r <= runState;
      // Program end outranks a software run in the same cycle
      if (progStop) begin
        runState <= 1'b0;
      end else if (runSet) begin
        runState <= 1'b1;
      end else if (runClr) begin
        runState <= 1'b0;
      end
    end
  end

  assign runStart = runState && !runPrev_r;
  assign progActive = (prog_r == pao_pkg::PG_SOAK);

  // ----------------------------------------
  // Manipulated variable
  // ----------------------------------------
  logic signed [16:0] dev;
  logic [7:0] mvHeatNxt;
  logic [7:0] mvCoolNxt;

  always_comb begin
    // Direct action turns a rising PV into a rising MV
    dev = ctrl_r.direct ? (17'(pv) - 17'(sp_r)) : (17'(sp_r) - 17'(pv));
    mvHeatNxt = 8'h00;
    mvCoolNxt = 8'h00;
    if (dev > 17'sd100) begin
      mvHeatNxt = pao_pkg::MV_MAX;
    end else if (dev > 17'sd0) begin
      mvHeatNxt = dev[7:0];
    end
    if (dev < -17'sd100) begin
      mvCoolNxt = pao_pkg::MV_MAX;
    end else if (dev < 17'sd0) begin
      mvCoolNxt = 8'(-dev);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mvHeat <= 8'h00;
      mvCool <= 8'h00;
    end else if (ce) begin
      mvHeat <= runState ? mvHeatNxt : 8'h00;
      mvCool <= (runState && ctrl_r.heatCool) ? mvCoolNxt : 8'h00;
    end
  end

  // ----------------------------------------
  // Time-proportioned outputs, 0 heat, 1 cool
  // ----------------------------------------
  logic [1:0] chOut_r;
  logic [1:0] chEn;

  assign chEn[0] = runState && !ctrl_r.linearHeat;
  assign chEn[1] = runState && ctrl_r.heatCool;

  for (genvar c = 0; c < 2; c++) begin : gCh
    logic [14:0] phase_r;
    logic [14:0] len;
    logic [7:0] mv;
    assign mv = (c == 0) ? mvHeat : mvCool;
    // Length in hundredths of a half second
    assign len = (per_r[c] == 8'h00) ? 15'(pao_pkg::STEPS_PER_HALF) :
                 15'(32'(per_r[c]) * pao_pkg::STEPS_PER_SEC);
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        phase_r <= '0;
        chOut_r[c] <= 1'b0;
      end else if (ce) begin
        if (centiTick) begin
          phase_r <= (phase_r >= len - 15'h0001) ? 15'h0000 : phase_r + 15'h0001;
        end
        // On for MV percent of the period, off for the rest
        chOut_r[c] <= chEn[c] &&
                      (32'(phase_r) * 100 < 32'(mv) * 32'(len));
      end
    end
  end

  assign heatOut = chOut_r[0];
  assign coolOut = chOut_r[1];

  // ----------------------------------------
  // Alarms
  // ----------------------------------------
  for (genvar i = 0; i < NA; i++) begin : gAlm
    localparam logic [7:0] BASE = 8'(32'(pao_pkg::OFF_ALM0) + i * pao_pkg::ALM_STRIDE);
    localparam logic [7:0] HOFF = 8'(32'(pao_pkg::OFF_HYS0) + i * 4);
    logic [3:0] t;
    logic signed [17:0] up;
    logic signed [17:0] lo;
    logic signed [17:0] hys;
    logic useUp;
    logic useLo;
    logic sby;
    logic overlap;
    logic raw;
    logic upSt_r;
    logic loSt_r;
    logic sbDone_r;
    logic typeWr_r;
    logic typeOk;
    logic hysOk;

    assign t = aType_r[i];
    // Alarm 0 alone may take the loop burnout code
    assign typeOk = (wdata <= 16'(pao_pkg::TYPE_MAX)) &&
                    !(i != 0 && wdata == 16'(pao_pkg::TYPE_LBA));
    // Hysteresis is locked while the type has no band
    assign hysOk = (wdata >= pao_pkg::HYS_MIN) && (wdata <= pao_pkg::HYS_MAX) &&
                   (t != 4'h0) && (t != pao_pkg::TYPE_LBA) &&
                   (t != pao_pkg::TYPE_RATE);

    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        aType_r[i] <= pao_pkg::TYPE_RST;
        aVal_r[i] <= '0;
        aHi_r[i] <= '0;
        aLo_r[i] <= '0;
        aHys_r[i] <= pao_pkg::HYS_RST;
      end else if (ce && we) begin
        if (addr == BASE + pao_pkg::OFF_ATYPE && typeOk) begin
          aType_r[i] <= wdata[3:0];
        end
        if (addr == BASE + pao_pkg::OFF_AVAL) begin
          aVal_r[i] <= wdata;
        end
        if (addr == BASE + pao_pkg::OFF_AHI) begin
          aHi_r[i] <= wdata;
        end
        if (addr == BASE + pao_pkg::OFF_ALO) begin
          aLo_r[i] <= wdata;
        end
        if (addr == HOFF && hysOk) begin
          aHys_r[i] <= wdata;
        end
      end
    end

    always_comb begin
      hys = 18'(aHys_r[i]);
      up = 18'(sp_r) + 18'(aVal_r[i]);
      lo = 18'(sp_r) - 18'(aVal_r[i]);
      useUp = 1'b0;
      useLo = 1'b0;
      sby = 1'b0;
      case (t)
        4'h1, 4'h4, 4'h5: begin
          up = 18'(sp_r) + 18'(aHi_r[i]);
          lo = 18'(sp_r) - 18'(aLo_r[i]);
          useUp = 1'b1;
          useLo = 1'b1;
          sby = (t == 4'h5);
        end
        4'h2, 4'h6: begin
          useUp = 1'b1;
          sby = (t == 4'h6);
        end
        4'h3, 4'h7: begin
          useLo = 1'b1;
          sby = (t == 4'h7);
        end
        4'h8, 4'hA: begin
          up = 18'(aVal_r[i]);
          useUp = 1'b1;
          sby = (t == 4'hA);
        end
        4'h9, 4'hB: begin
          lo = 18'(aVal_r[i]);
          useLo = 1'b1;
          sby = (t == 4'hB);
        end
        default: ;
      endcase
      overlap = (up - hys) <= (lo + hys);
      if (t == 4'h4) begin
        raw = !(upSt_r || loSt_r);
      end else begin
        raw = (useUp && upSt_r) || (useLo && loSt_r);
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        upSt_r <= 1'b0;
        loSt_r <= 1'b0;
        sbDone_r <= 1'b0;
        typeWr_r <= 1'b0;
        almRaw[i] <= 1'b0;
      end else if (ce) begin
        // Release only once back inside by the hysteresis
        if (18'(pv) > up) begin
          upSt_r <= 1'b1;
        end else if (18'(pv) <= up - hys) begin
          upSt_r <= 1'b0;
        end
        if (18'(pv) < lo) begin
          loSt_r <= 1'b1;
        end else if (18'(pv) >= lo + hys) begin
          loSt_r <= 1'b0;
        end
        // Standby rearms at run start and on any write to the type address; the extra cycle
        // covers band state that still lags the new thresholds
        typeWr_r <= we && addr == BASE + pao_pkg::OFF_ATYPE;
        if (runStart || typeWr_r || (we && addr == BASE + pao_pkg::OFF_ATYPE)) begin
          sbDone_r <= 1'b0;
        end else if (!raw) begin
          sbDone_r <= 1'b1;
        end
        almRaw[i] <= raw && (!sby || sbDone_r) && !(t == 4'h5 && overlap);
      end
    end
  end

  assign alarmOut = almRaw;

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb begin
    rdNxt = 16'h0000;
    case (addr)
      pao_pkg::OFF_CTRL: rdNxt = {11'h000, ctrl_r};
      pao_pkg::OFF_STAT: rdNxt = {9'h000, coolOut, heatOut, alarmOut, progActive, runState};
      pao_pkg::OFF_SP: rdNxt = sp_r;
      pao_pkg::OFF_HPER: rdNxt = {8'h00, per_r[0]};
      pao_pkg::OFF_CPER: rdNxt = {8'h00, per_r[1]};
      pao_pkg::OFF_SOAK: rdNxt = soak_r;
      pao_pkg::OFF_MV: rdNxt = {mvCool, mvHeat};
      default: ;
    endcase
    for (int k = 0; k < NA; k++) begin
      if (addr == 8'(32'(pao_pkg::OFF_ALM0) + k * pao_pkg::ALM_STRIDE)) begin
        rdNxt = {12'h000, aType_r[k]};
      end
      if (addr == 8'(32'(pao_pkg::OFF_ALM0) + k * pao_pkg::ALM_STRIDE + 4)) begin
        rdNxt = aVal_r[k];
      end
      if (addr == 8'(32'(pao_pkg::OFF_ALM0) + k * pao_pkg::ALM_STRIDE + 8)) begin
        rdNxt = aHi_r[k];
      end
      if (addr == 8'(32'(pao_pkg::OFF_ALM0) + k * pao_pkg::ALM_STRIDE + 12)) begin
        rdNxt = aLo_r[k];
      end
      if (addr == 8'(32'(pao_pkg::OFF_HYS0) + k * 4)) begin
        rdNxt = aHys_r[k];
      end
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      rdata <= re ? rdNxt : 16'h0000;
    end
  end
endmodule // pao_top

// [dv/pao_plant.sv]
// Partner model: load switched by heatOut or coolOut and sensor path in front of pao_top
`timescale 1ns/1ps
module pao_plant (
  input wire logic sys_clk,
  input wire logic heatOut,
  input wire logic coolOut,
  input wire logic signed [15:0] pvSet,
  output logic signed [15:0] pv,
  output logic loadOn
);
  // Sensor lags one cycle; the bench sets the settled value
  always_ff @(posedge sys_clk) begin
    pv <= pvSet;
  end
  assign loadOn = heatOut | coolOut;
endmodule // pao_plant

// [dv/pao_top_assertions.sv]
// Checker: concurrent assertions on the ports of pao_top
`timescale 1ns/1ps
module pao_top_assertions (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic we,
  input wire logic re,
  input wire logic [15:0] rdata,
  input wire logic signed [15:0] pv,
  input wire logic heatOut,
  input wire logic coolOut,
  input wire logic [2:0] alarmOut,
  input wire logic runState,
  input wire logic progActive,
  input wire logic [7:0] mvHeat,
  input wire logic [7:0] mvCool
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  a_reset_clear: assert property ($past(rstn) == 1'b0 |->
    !runState && !heatOut && alarmOut == 3'h0)
    else $error("outputs not clear after reset");
  a_idle_off: assert property (ce && !runState && !$past(runState) && !$past(runState, 2)
    |-> mvHeat == 8'h00 && mvCool == 8'h00 && !heatOut && !coolOut)
    else $error("outputs active while stopped");
  a_mv_range: assert property (mvHeat <= 8'h64 && mvCool <= 8'h64)
    else $error("manipulated variable above full scale");
  a_mv_one_sign: assert property (mvHeat != 8'h00 |-> mvCool == 8'h00)
    else $error("heating and cooling demand at once");
  a_heat_needs_mv: assert property (heatOut |->
    mvHeat != 8'h00 || $past(mvHeat) != 8'h00)
    else $error("heating output on with zero demand");
  a_cool_needs_mv: assert property (coolOut |->
    mvCool != 8'h00 || $past(mvCool) != 8'h00)
    else $error("cooling output on with zero demand");
  a_rdata_idle: assert property ($past(ce) && !$past(re) |-> rdata == 16'h0000)
    else $error("read data outside its cycle");
  // Idle bus and steady value must leave the alarms settled
  a_alarm_settled: assert property ($past(rstn, 4) && !$past(we) &&
    !$past(we, 2) && !$past(we, 3) && $past(pv) == $past(pv, 3) &&
    $past(pv, 2) == $past(pv, 3) |-> $stable(alarmOut))
    else $error("alarm moved with steady process value");
endmodule // pao_top_assertions

bind pao_top pao_top_assertions pao_top_assertions_i (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
  .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata), .pv(pv), .heatOut(heatOut),
  .coolOut(coolOut), .alarmOut(alarmOut), .runState(runState), .progActive(progActive),
  .mvHeat(mvHeat), .mvCool(mvCool));

// [dv/tb_top.sv]
// Testbench: register, alarm, output period and program scenarios for pao_top
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, got, exp); end end
module tb_top;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [15:0] rdata;
  logic signed [15:0] pvSet = 16'sh0064;
  logic signed [15:0] pv;
  logic heatOut, coolOut, runState, progActive;
  logic [2:0] alarmOut;
  logic [7:0] mvHeat, mvCool;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  always #2 sys_clk = ~sys_clk;
  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  // Four cycles a step keeps a 2 s period at 1600 cycles
  pao_top #(.CENTI_CYC(4)) pao_top_i (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .addr(addr),
    .wdata(wdata), .we(we), .re(re), .rdata(rdata), .pv(pv), .heatOut(heatOut),
    .coolOut(coolOut), .alarmOut(alarmOut), .runState(runState), .progActive(progActive),
    .mvHeat(mvHeat), .mvCool(mvCool));
  pao_plant pao_plant_i (.sys_clk(sys_clk), .heatOut(heatOut), .coolOut(coolOut),
    .pvSet(pvSet), .pv(pv), .loadOn());
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude();
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge sys_clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    addr <= a;
    re <= 1'b1;
    @(posedge sys_clk);
    re <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic pvchk(input logic signed [15:0] p, input logic e);
    @(posedge sys_clk);
    pvSet <= p;
    wait_cyc(5);
    #1;
    `CHK(alarmOut[0], e)
    `CHK(alarmOut[2:1], 2'b01)
  endtask
  // Type written last so the standby sequence rearms at the neutral value
  task automatic al(input logic [3:0] t, input logic [15:0] x, h, l,
                    input logic signed [15:0] pn, pt, input logic e);
    @(posedge sys_clk);
    pvSet <= pn;
    wait_cyc(4);
    wr(8'h24, x);
    wr(8'h28, h);
    wr(8'h2C, l);
    wr(pao_pkg::OFF_ALM0, {12'h000, t});
    wait_cyc(4);
    pvchk(pt, e);
  endtask
  task automatic oc(input logic [15:0] ctl, hp, cp, input logic signed [15:0] p,
                    input logic [7:0] eh, ec, input int nh, nc);
    int h = 0;
    int c = 0;
    wr(pao_pkg::OFF_HPER, hp);
    wr(pao_pkg::OFF_CPER, cp);
    wr(pao_pkg::OFF_CTRL, ctl);
    pvSet <= p;
    wait_cyc(1700);
    #1;
    `CHK(mvHeat, eh)
    `CHK(mvCool, ec)
    repeat (1600) begin
      @(posedge sys_clk);
      #1;
      if (heatOut === 1'b1) h++;
      if (coolOut === 1'b1) c++;
    end
    `CHK(h, nh)
    `CHK(c, nc)
  endtask
  task automatic prog(input logic [15:0] ctl, input logic endRun);
    int n;
    // Pattern first: a start is judged against the stored pattern
    wr(pao_pkg::OFF_CTRL, ctl & 16'hFFBF);
    wr(pao_pkg::OFF_CTRL, ctl);
    wait_cyc(4);
    #1;
    `CHK(progActive, 1'b1)
    for (n = 0; n < 3000 && progActive === 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    wait_cyc(3);
    #1;
    `CHK(runState, endRun)
  endtask
  // ----------------------------------------
  // Hang guard and main sequence
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    wait_cyc(4);
    rstn <= 1'b1;
    rd(pao_pkg::OFF_CTRL, 16'h0000);
    rd(pao_pkg::OFF_HPER, 16'h0014);
    rd(pao_pkg::OFF_CPER, 16'h0014);
    for (int i = 0; i < 3; i++) begin
      rd(8'(pao_pkg::OFF_ALM0 + 16 * i), 16'h0002);
      rd(8'(pao_pkg::OFF_HYS0 + 4 * i), 16'h0002);
    end
    rd(8'hFE, 16'h0000);
    wr(pao_pkg::OFF_HPER, 16'h0064);
    rd(pao_pkg::OFF_HPER, 16'h0014);
    wr(pao_pkg::OFF_HPER, 16'h0063);
    rd(pao_pkg::OFF_HPER, 16'h0063);
    wr(pao_pkg::OFF_ALM0, 16'h000E);
    rd(pao_pkg::OFF_ALM0, 16'h0002);
    wr(8'h30, 16'h000C);
    rd(8'h30, 16'h0002);
    wr(pao_pkg::OFF_ALM0, 16'h000C);
    rd(pao_pkg::OFF_ALM0, 16'h000C);
    wr(8'h54, 16'h0000);
    wr(8'h54, 16'h2710);
    rd(8'h54, 16'h0002);
    wr(8'h54, 16'h270F);
    rd(8'h54, 16'h270F);
    wr(8'h40, 16'h0000);
    wr(8'h58, 16'h0005);
    rd(8'h58, 16'h0002);
    wr(pao_pkg::OFF_SP, 16'h0064);
    al(4'h0, 16'h0000, 16'h0000, 16'h0000, 100, 500, 1'b0);
    al(4'hC, 16'h0000, 16'h0000, 16'h0000, 100, 500, 1'b0);
    al(4'hD, 16'h0000, 16'h0000, 16'h0000, 100, 500, 1'b0);
    al(4'h2, 16'h000A, 16'h0000, 16'h0000, 100, 110, 1'b0);
    pvchk(111, 1'b1);
    pvchk(109, 1'b1);
    pvchk(108, 1'b0);
    al(4'h3, 16'h000A, 16'h0000, 16'h0000, 100, 89, 1'b1);
    al(4'h3, 16'h000A, 16'h0000, 16'h0000, 100, 90, 1'b0);
    al(4'h8, 16'h0032, 16'h0000, 16'h0000, 0, 51, 1'b1);
    al(4'h8, 16'h0032, 16'h0000, 16'h0000, 0, 50, 1'b0);
    al(4'h9, 16'h0032, 16'h0000, 16'h0000, 100, 49, 1'b1);
    al(4'h1, 16'h0000, 16'h0005, 16'h0005, 100, 106, 1'b1);
    al(4'h1, 16'h0000, 16'h0005, 16'h0005, 100, 94, 1'b1);
    al(4'h4, 16'h0000, 16'h0005, 16'h0005, 100, 100, 1'b1);
    al(4'h4, 16'h0000, 16'h0005, 16'h0005, 100, 106, 1'b0);
    al(4'h6, 16'h000A, 16'h0000, 16'h0000, 100, 111, 1'b1);
    al(4'h6, 16'h000A, 16'h0000, 16'h0000, 120, 120, 1'b0);
    al(4'h7, 16'h000A, 16'h0000, 16'h0000, 80, 80, 1'b0);
    al(4'hA, 16'h0032, 16'h0000, 16'h0000, 60, 60, 1'b0);
    al(4'hB, 16'h0032, 16'h0000, 16'h0000, 40, 40, 1'b0);
    al(4'h5, 16'h0000, 16'h0005, 16'h0005, 120, 120, 1'b0);
    al(4'h5, 16'h0000, 16'h0005, 16'h0005, 100, 106, 1'b1);
    al(4'h5, 16'h0000, 16'h0001, 16'h0001, 100, 110, 1'b0);
    oc(16'h0020, 16'h0000, 16'h0001, 75, 8'h19, 8'h00, 400, 0);
    rd(pao_pkg::OFF_MV, 16'h0019);
    oc(16'h0024, 16'h0000, 16'h0001, 130, 8'h1E, 8'h00, 480, 0);
    oc(16'h0020, 16'h0000, 16'h0001, -100, 8'h64, 8'h00, 1600, 0);
    oc(16'h0028, 16'h0000, 16'h0001, 120, 8'h00, 8'h14, 0, 320);
    oc(16'h0028, 16'h0000, 16'h0001, 90, 8'h0A, 8'h00, 160, 0);
    oc(16'h0028, 16'h0002, 16'h0000, 85, 8'h0F, 8'h00, 240, 0);
    oc(16'h0030, 16'h0000, 16'h0001, 50, 8'h32, 8'h00, 0, 0);
    oc(16'h0000, 16'h0000, 16'h0001, 50, 8'h00, 8'h00, 0, 0);
    // Clock enable low must drop the write
    ce <= 1'b0;
    wr(pao_pkg::OFF_SP, 16'h0055);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd(pao_pkg::OFF_SP, 16'h0064);
    rd(pao_pkg::OFF_STAT, 16'h0008);
    wr(pao_pkg::OFF_SOAK, 16'h0001);
    wr(pao_pkg::OFF_CTRL, 16'h0060);
    wait_cyc(4);
    #1;
    `CHK(progActive, 1'b0)
    prog(16'h0061, 1'b0);
    prog(16'h0062, 1'b1);
    conclude();
  end
endmodule // tb_top
